//--- design/ssl_cfg.svh
// ssl_cfg.svh: offsets, field positions, reset values and timing of the
// supply supervisor low-power state logic; plain definitions only
`ifndef SSL_CFG_SVH
`define SSL_CFG_SVH

// register byte offsets on the AHB-Lite bus
`define SSL_OFF_HCTL   8'h00
`define SSL_OFF_LCTL   8'h04
`define SSL_OFF_MODE   8'h08
`define SSL_OFF_STAT   8'h0C
`define SSL_OFF_IFG    8'h10
`define SSL_OFF_IE     8'h14

// control field positions, same for high and low control registers
`define SSL_B_SUP_EN   0
`define SSL_B_SUP_MD   1
`define SSL_B_SUP_FP   2
`define SSL_B_AUTO     3
`define SSL_B_MON_EN   4
`define SSL_B_MON_FP   5
`define SSL_CTL_W      6

// status fields
`define SSL_B_LDLY     0
`define SSL_B_HDLY     1
`define SSL_B_SUPST    2
`define SSL_B_MONST    4
`define SSL_B_AFFECT   6
`define SSL_B_WSLOW    7
`define SSL_B_DEEP     8

// event flag positions
`define SSL_E_LSET     0
`define SSL_E_HSET     1
`define SSL_E_HAZ      2
`define SSL_E_WAKE     3
`define SSL_EV_W       4

// reset values
`define SSL_RST_HCTL   6'h00
`define SSL_RST_LCTL   6'h00
`define SSL_RST_MODE   3'h0
`define SSL_RST_IE     4'h0

// timing
`define SSL_CLK_MHZ    50
`define SSL_SLOW_US    150
`define SSL_FAST_US    2

`endif

//--- design/ssl_pkg.sv
// ssl_pkg: types and the configuration check of the supervisor state logic
// assumes ssl_cfg.svh is on the include path
package ssl_pkg;
  `include "ssl_cfg.svh"

  // operating state of one supervisor or monitor
  typedef enum logic [1:0] {SSL_OFF, SSL_NORMAL, SSL_FULL} ssl_sup_state_t;

  // power mode field: active, light 0/1, deep 2/3/4
  typedef enum logic [2:0] {SSL_AM, SSL_LP0, SSL_LP1, SSL_LP2, SSL_LP3, SSL_LP4} ssl_mode_t;

  // low side counts as fast wake-up
  function automatic logic ssl_low_fast(input logic [`SSL_CTL_W-1:0] l);
    ssl_low_fast = !l[`SSL_B_SUP_EN] || l[`SSL_B_SUP_FP] ||
                   !l[`SSL_B_MON_EN] || l[`SSL_B_MON_FP];
  endfunction

  // 1 for an affected configuration, 0 otherwise
  function automatic logic ssl_affected(input logic [`SSL_CTL_W-1:0] h,
                                        input logic [`SSL_CTL_W-1:0] l);
    logic sup_haz;
    logic mon_haz;
    sup_haz = h[`SSL_B_SUP_EN] && !h[`SSL_B_SUP_FP] &&
              (!h[`SSL_B_SUP_MD] || (h[`SSL_B_SUP_MD] && h[`SSL_B_AUTO]));
    mon_haz = h[`SSL_B_MON_EN] && !h[`SSL_B_MON_FP] && h[`SSL_B_AUTO];
    ssl_affected = ssl_low_fast(l) && (sup_haz || mon_haz);
  endfunction
endpackage

//--- design/ssl_state_dec.sv
// ssl_state_dec: combinational state decode of one high-side supervisor or monitor
// assumes a monitor is fed with sleep_mode tied high
`timescale 1ns/1ns
module ssl_state_dec (
  // configuration
  input  wire logic                    enable,
  input  wire logic                    sleep_mode,
  input  wire logic                    perf,
  input  wire logic                    auto_ctrl,
  input  wire logic                    deep,
  // resulting state
  output ssl_pkg::ssl_sup_state_t      state
);
  import ssl_pkg::*;

  // active/light follow perf; deep follows manual or automatic table
  always_comb begin
    if (!enable) begin
      state = SSL_OFF;
    end else if (!deep) begin
      state = perf ? SSL_FULL : SSL_NORMAL;
    end else if (!auto_ctrl) begin
      state = !sleep_mode ? SSL_OFF : (perf ? SSL_FULL : SSL_NORMAL);
    end else begin
      state = (sleep_mode && perf) ? SSL_NORMAL : SSL_OFF;
    end
  end
endmodule // ssl_state_dec

//--- design/ssl_supervisor.sv
// ssl_supervisor: high-side supervisor low-power state logic, AHB-Lite slave
// assumes a single AHB-Lite master doing single word transfers, one at a time
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`include "ssl_cfg.svh"
module ssl_supervisor #(
  parameter int unsigned SLOW_CYC = `SSL_SLOW_US * `SSL_CLK_MHZ,
  parameter int unsigned FAST_CYC = `SSL_FAST_US * `SSL_CLK_MHZ
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // AHB-Lite slave
  input  wire logic                    hsel,
  input  wire logic [7:0]              haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic                    hready,
  input  wire logic [31:0]             hwdata,
  output logic      [31:0]             hrdata,
  output logic                         hreadyout,
  output logic                         hresp,
  // wake-up and outputs
  input  wire logic                    wake_req,
  output logic                         irq,
  output logic                         deep_sleep,
  output logic                         wake_busy,
  output ssl_pkg::ssl_sup_state_t      high_sup_state,
  output ssl_pkg::ssl_sup_state_t      high_mon_state
);
  import ssl_pkg::*;

  // refuse cycle counts that the 16-bit counters cannot hold
  if (SLOW_CYC < 1 || SLOW_CYC > 65535 || FAST_CYC < 1 || FAST_CYC > 65535) begin : g_bad_cyc
    $error("ssl_supervisor: cycle counts must be 1..65535");
  end

  typedef enum logic [1:0] {SSL_RUN, SSL_SLEEP, SSL_WAKE} ssl_seq_t;

  localparam logic [15:0] SLOW_C = SLOW_CYC[15:0];
  localparam logic [15:0] FAST_C = FAST_CYC[15:0];

  logic [`SSL_CTL_W-1:0] hctl_q;
  logic [`SSL_CTL_W-1:0] lctl_q;
  ssl_mode_t             mode_q;
  logic [`SSL_EV_W-1:0]  ifg_q;
  logic [`SSL_EV_W-1:0]  ie_q;
  logic [`SSL_EV_W-1:0]  ev_set;
  logic [`SSL_EV_W-1:0]  ev_clr;
  logic                  ldly_q;
  logic                  hdly_q;
  logic [15:0]           lcnt_q;
  logic [15:0]           hcnt_q;
  logic [15:0]           wcnt_q;
  ssl_seq_t              seq_q;
  logic                  wr_q;
  logic [7:0]            waddr_q;
  logic                  addr_ok;
  logic                  rd_go;
  logic                  wr_now;
  logic                  deep_entry;
  logic                  affected;
  logic                  wslow;
  logic                  norm_to_off;
  logic [31:0]           rd_mux;
  ssl_sup_state_t        sup_act;
  ssl_sup_state_t        mon_act;
  ssl_sup_state_t        sup_dp;
  ssl_sup_state_t        mon_dp;

  // active and deep state decode of the high supervisor and monitor
  ssl_state_dec u_sup_act (.enable(hctl_q[`SSL_B_SUP_EN]), .sleep_mode(hctl_q[`SSL_B_SUP_MD]),
    .perf(hctl_q[`SSL_B_SUP_FP]), .auto_ctrl(hctl_q[`SSL_B_AUTO]), .deep(1'b0), .state(sup_act));
  ssl_state_dec u_sup_dp (.enable(hctl_q[`SSL_B_SUP_EN]), .sleep_mode(hctl_q[`SSL_B_SUP_MD]),
    .perf(hctl_q[`SSL_B_SUP_FP]), .auto_ctrl(hctl_q[`SSL_B_AUTO]), .deep(1'b1), .state(sup_dp));
  ssl_state_dec u_mon_act (.enable(hctl_q[`SSL_B_MON_EN]), .sleep_mode(1'b1),
    .perf(hctl_q[`SSL_B_MON_FP]), .auto_ctrl(hctl_q[`SSL_B_AUTO]), .deep(1'b0), .state(mon_act));
  ssl_state_dec u_mon_dp (.enable(hctl_q[`SSL_B_MON_EN]), .sleep_mode(1'b1),
    .perf(hctl_q[`SSL_B_MON_FP]), .auto_ctrl(hctl_q[`SSL_B_AUTO]), .deep(1'b1), .state(mon_dp));

  // configuration check and wake speed
  assign affected = ssl_affected(hctl_q, lctl_q);
  assign wslow    = !ssl_low_fast(lctl_q);
  assign norm_to_off = (sup_act == SSL_NORMAL && sup_dp == SSL_OFF) ||
                       (mon_act == SSL_NORMAL && mon_dp == SSL_OFF);

  // bus address phase decode
  assign addr_ok = haddr[1:0] == 2'b00 && haddr <= `SSL_OFF_IE;
  assign rd_go   = hsel && hready && htrans[1] && !hwrite;
  assign wr_now  = wr_q;
  assign deep_entry = wr_now && waddr_q == `SSL_OFF_MODE && hwdata[2:0] >= 3'(SSL_LP2)
                      && hwdata[2:0] <= 3'(SSL_LP4);

  // bus handshake: zero wait, always OKAY
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wr_q      <= 1'b0;
      waddr_q   <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_q      <= hsel && hready && htrans[1] && hwrite && addr_ok;
      waddr_q   <= haddr;
    end
  end

  // read data, captured in the address phase; unmapped reads give zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr)
      `SSL_OFF_HCTL: rd_mux[`SSL_CTL_W-1:0] = hctl_q;
      `SSL_OFF_LCTL: rd_mux[`SSL_CTL_W-1:0] = lctl_q;
      `SSL_OFF_MODE: rd_mux[2:0] = mode_q;
      `SSL_OFF_STAT: begin
        rd_mux[`SSL_B_LDLY] = ldly_q;
        rd_mux[`SSL_B_HDLY] = hdly_q;
        rd_mux[`SSL_B_SUPST +: 2] = high_sup_state;
        rd_mux[`SSL_B_MONST +: 2] = high_mon_state;
        rd_mux[`SSL_B_AFFECT] = affected;
        rd_mux[`SSL_B_WSLOW] = wslow;
        rd_mux[`SSL_B_DEEP] = deep_sleep;
      end
      `SSL_OFF_IFG:  rd_mux[`SSL_EV_W-1:0] = ifg_q;
      `SSL_OFF_IE:   rd_mux[`SSL_EV_W-1:0] = ie_q;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_go) begin
      hrdata <= rd_mux;
    end
  end

  // control registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hctl_q <= `SSL_RST_HCTL;
      lctl_q <= `SSL_RST_LCTL;
      ie_q   <= `SSL_RST_IE;
    end else if (wr_now) begin
      if (waddr_q == `SSL_OFF_HCTL) hctl_q <= hwdata[`SSL_CTL_W-1:0];
      if (waddr_q == `SSL_OFF_LCTL) lctl_q <= hwdata[`SSL_CTL_W-1:0];
      if (waddr_q == `SSL_OFF_IE)   ie_q   <= hwdata[`SSL_EV_W-1:0];
    end
  end

  // settling delays after control writes; length follows the side's perf bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ldly_q <= 1'b0;
      hdly_q <= 1'b0;
      lcnt_q <= 16'h0000;
      hcnt_q <= 16'h0000;
    end else begin
      if (wr_now && waddr_q == `SSL_OFF_LCTL) begin
        ldly_q <= 1'b1;
        lcnt_q <= hwdata[`SSL_B_SUP_FP] ? FAST_C : SLOW_C;
      end else if (ldly_q) begin
        lcnt_q <= lcnt_q - 16'h0001;
        if (lcnt_q == 16'h0001) ldly_q <= 1'b0;
      end
      if (wr_now && waddr_q == `SSL_OFF_HCTL) begin
        hdly_q <= 1'b1;
        hcnt_q <= hwdata[`SSL_B_SUP_FP] ? FAST_C : SLOW_C;
      end else if (hdly_q) begin
        hcnt_q <= hcnt_q - 16'h0001;
        if (hcnt_q == 16'h0001) hdly_q <= 1'b0;
      end
    end
  end

  // mode and sleep sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= ssl_mode_t'(`SSL_RST_MODE);
      seq_q  <= SSL_RUN;
      wcnt_q <= 16'h0000;
    end else begin
      unique case (seq_q)
        SSL_RUN: begin
          if (wr_now && waddr_q == `SSL_OFF_MODE && hwdata[2:0] <= 3'(SSL_LP4)) begin
            mode_q <= ssl_mode_t'(hwdata[2:0]);
            if (deep_entry) seq_q <= SSL_SLEEP;
          end
        end
        SSL_SLEEP: begin
          if (wake_req) begin
            seq_q  <= SSL_WAKE;
            wcnt_q <= wslow ? SLOW_C : FAST_C;
          end
        end
        SSL_WAKE: begin
          wcnt_q <= wcnt_q - 16'h0001;
          if (wcnt_q == 16'h0001) begin
            seq_q  <= SSL_RUN;
            mode_q <= SSL_AM;
          end
        end
        default: seq_q <= SSL_RUN;                                  // unused code recovers
      endcase
    end
  end

  // events: settle done, hazardous deep entry, wake done
  always_comb begin
    ev_set = '0;
    ev_set[`SSL_E_LSET] = ldly_q && lcnt_q == 16'h0001 && !(wr_now && waddr_q == `SSL_OFF_LCTL);
    ev_set[`SSL_E_HSET] = hdly_q && hcnt_q == 16'h0001 && !(wr_now && waddr_q == `SSL_OFF_HCTL);
    ev_set[`SSL_E_HAZ]  = seq_q == SSL_RUN && deep_entry &&
                          (ldly_q || hdly_q || (norm_to_off && !wslow));
    ev_set[`SSL_E_WAKE] = seq_q == SSL_WAKE && wcnt_q == 16'h0001;
    ev_clr = (rd_go && haddr == `SSL_OFF_IFG) ? {`SSL_EV_W{1'b1}} : '0;
  end

  // sticky flags; a new event wins over the read clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ifg_q <= '0;
    end else begin
      ifg_q <= (ifg_q & ~ev_clr) | ev_set;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq            <= 1'b0;
      deep_sleep     <= 1'b0;
      wake_busy      <= 1'b0;
      high_sup_state <= SSL_OFF;
      high_mon_state <= SSL_OFF;
    end else begin
      irq            <= |(((ifg_q & ~ev_clr) | ev_set) & ie_q);
      deep_sleep     <= seq_q == SSL_SLEEP;
      wake_busy      <= seq_q == SSL_WAKE;
      high_sup_state <= seq_q == SSL_SLEEP ? sup_dp : sup_act;
      high_mon_state <= seq_q == SSL_SLEEP ? mon_dp : mon_act;
    end
  end

  // assertions
  property p_off_when_disabled;
    @(posedge clk) disable iff (sys_rst)
      !hctl_q[`SSL_B_SUP_EN] |=> high_sup_state == SSL_OFF;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled) else $error("sup not off");

  property p_active_perf;
    @(posedge clk) disable iff (sys_rst)
      seq_q != SSL_SLEEP && hctl_q[`SSL_B_SUP_EN] |=>
        high_sup_state == ($past(hctl_q[`SSL_B_SUP_FP]) ? SSL_FULL : SSL_NORMAL);
  endproperty
  a_active_perf: assert property (p_active_perf) else $error("active state wrong");

  property p_auto_deep;
    @(posedge clk) disable iff (sys_rst)
      seq_q == SSL_SLEEP && hctl_q[`SSL_B_AUTO] && hctl_q[`SSL_B_SUP_EN] |=>
        high_sup_state == ($past(hctl_q[`SSL_B_SUP_MD] && hctl_q[`SSL_B_SUP_FP])
                           ? SSL_NORMAL : SSL_OFF);
  endproperty
  a_auto_deep: assert property (p_auto_deep) else $error("auto deep state wrong");

  property p_haz_flag;
    @(posedge clk) disable iff (sys_rst)
      seq_q == SSL_RUN && deep_entry && (ldly_q || hdly_q) |=> ifg_q[`SSL_E_HAZ];
  endproperty
  a_haz_flag: assert property (p_haz_flag) else $error("hazard not flagged");

  property p_fast_low;
    @(posedge clk) disable iff (sys_rst)
      !lctl_q[`SSL_B_SUP_EN] |-> !wslow;
  endproperty
  a_fast_low: assert property (p_fast_low) else $error("low side not fast");

  property p_sup_haz;
    @(posedge clk) disable iff (sys_rst)
      !lctl_q[`SSL_B_SUP_EN] && hctl_q[`SSL_B_SUP_EN] && !hctl_q[`SSL_B_SUP_FP] &&
      !hctl_q[`SSL_B_SUP_MD] |-> affected;
  endproperty
  a_sup_haz: assert property (p_sup_haz) else $error("sup hazard missed");

  property p_mon_haz;
    @(posedge clk) disable iff (sys_rst)
      !lctl_q[`SSL_B_MON_EN] && hctl_q[`SSL_B_MON_EN] && !hctl_q[`SSL_B_MON_FP] &&
      hctl_q[`SSL_B_AUTO] |-> affected;
  endproperty
  a_mon_haz: assert property (p_mon_haz) else $error("mon hazard missed");

  property p_unaffected;
    @(posedge clk) disable iff (sys_rst)
      lctl_q[`SSL_B_SUP_EN] && !lctl_q[`SSL_B_SUP_FP] && lctl_q[`SSL_B_MON_EN] &&
      !lctl_q[`SSL_B_MON_FP] |-> !affected;
  endproperty
  a_unaffected: assert property (p_unaffected) else $error("slow wake marked affected");

  property p_slow_wake;
    @(posedge clk) disable iff (sys_rst)
      seq_q == SSL_SLEEP && wake_req && wslow |=> wcnt_q == SLOW_C;
  endproperty
  a_slow_wake: assert property (p_slow_wake) else $error("slow wake count wrong");

  c_deep: cover property (@(posedge clk) disable iff (sys_rst) seq_q == SSL_SLEEP);
  c_haz: cover property (@(posedge clk) disable iff (sys_rst) ev_set[`SSL_E_HAZ]);
  c_wake: cover property (@(posedge clk) disable iff (sys_rst) ev_set[`SSL_E_WAKE]);
endmodule // ssl_supervisor

//--- testbench/ssl_supervisor_bench.sv
// ssl_supervisor_bench: register-level bench of the supervisor state logic
// assumes ssl_pkg and ssl_supervisor compiled first, ssl_cfg.svh on the include path
`timescale 1ns/1ns
`include "ssl_cfg.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; $display("[ERR] %0t got %h want %h", $time, a, b); end end

module ssl_supervisor_bench;
  import ssl_pkg::*;
  localparam int SLOW = 20;
  localparam int FAST = 4;
  logic                clk      = 1'b0;
  logic                sys_rst  = 1'b1;
  logic                hsel     = 1'b1;
  logic                hwrite   = 1'b0;
  logic                wake_req = 1'b0;
  logic [7:0]          haddr    = 8'h00;
  logic [1:0]          htrans   = 2'h0;
  logic [2:0]          hsize    = 3'h0;
  logic [31:0]         hwdata   = 32'h0;
  logic [31:0]         hrdata;
  logic [31:0]         r;
  logic                hreadyout;
  logic                hresp;
  logic                irq;
  logic                deep_sleep;
  logic                wake_busy;
  ssl_sup_state_t      high_sup_state;
  ssl_sup_state_t      high_mon_state;
  int                  mismatches = 0;
  int                  cmp_count  = 0;
  logic [5:0]          lv [4] = '{6'h00, 6'h11, 6'h15, 6'h31};
  logic [5:0]          hv [8] = '{6'h03, 6'h0B, 6'h0F, 6'h07, 6'h01, 6'h30, 6'h18, 6'h00};

  // clock of 20 ns
  always #10 clk = ~clk;

  ssl_supervisor #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wake_req(wake_req), .irq(irq),
    .deep_sleep(deep_sleep), .wake_busy(wake_busy), .high_sup_state(high_sup_state),
    .high_mon_state(high_mon_state));

  // expected values worked out from the control bits
  function automatic logic [1:0] act(input logic en, input logic fp);
    return en ? (fp ? 2'h2 : 2'h1) : 2'h0;
  endfunction
  function automatic logic lfast(input logic [5:0] l);
    return !l[0] || l[2] || !l[4] || l[5];
  endfunction
  function automatic logic aff(input logic [5:0] h, input logic [5:0] l);
    return lfast(l) && ((h[0] && !h[2] && (!h[1] || h[3])) || (h[4] && !h[5] && h[3]));
  endfunction
  function automatic logic [1:0] dsup(input logic [5:0] h);
    if (!h[0]) return 2'h0;
    if (!h[3]) return h[1] ? act(1'b1, h[2]) : 2'h0;
    return (h[1] && h[2]) ? 2'h1 : 2'h0;
  endfunction
  function automatic logic [1:0] dmon(input logic [5:0] h);
    if (!h[4]) return 2'h0;
    return h[3] ? {1'b0, h[5]} : act(1'b1, h[5]);
  endfunction

  // one single-word transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd_v);
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clk); while (!hreadyout);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (!hreadyout);
    rd_v = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // deep entry with a given setup, then wake-up and its timing
  task automatic deep_case(input logic [5:0] h, input logic [5:0] l, input logic settle);
    logic [31:0] q;
    logic        haz;
    int          n;
    int          want;
    haz  = !settle || aff(h, l);
    want = lfast(l) ? FAST : SLOW;
    wr(`SSL_OFF_LCTL, {26'h0, l});
    wr(`SSL_OFF_HCTL, {26'h0, h});
    if (settle) begin
      rd(`SSL_OFF_STAT, q);
      `CHK(q[1:0], 2'h3)
      tick(SLOW + 4);
      rd(`SSL_OFF_STAT, q);
      `CHK(q[1:0], 2'h0)
    end
    rd(`SSL_OFF_IFG, q);
    if (settle) `CHK(q[1:0], 2'h3)
    wr(`SSL_OFF_MODE, 32'h3);
    tick(3);
    `CHK(deep_sleep, 1'b1)
    `CHK(high_sup_state, dsup(h))
    `CHK(high_mon_state, dmon(h))
    `CHK(irq, haz)
    rd(`SSL_OFF_IFG, q);
    `CHK(q[2], haz)
    tick(2);
    `CHK(irq, 1'b0)
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (!wake_busy && n < 5);
    n = 0;
    while (wake_busy && n < 200) begin @(posedge clk); n++; end
    `CHK(n >= want - 1 && n <= want + 2, 1'b1)
    tick(2);
    `CHK(deep_sleep, 1'b0)
    rd(`SSL_OFF_MODE, q);
    `CHK(q, 32'h0)
    rd(`SSL_OFF_IFG, q);
    `CHK(q[3], 1'b1)
  endtask

  // verdict and end of run
  task automatic results();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    tick(2);
    rd(`SSL_OFF_HCTL, r);
    `CHK(r, 32'h0)
    rd(`SSL_OFF_IE, r);
    `CHK(r, 32'h0)
    rd(8'h20, r);
    `CHK(r, 32'h0)
    rd(`SSL_OFF_STAT, r);
    `CHK(r[8:2], 7'h0)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
    // light mode is kept, out-of-range mode ignored, neither sleeps
    wr(`SSL_OFF_MODE, 32'h2);
    wr(`SSL_OFF_MODE, 32'h6);
    rd(`SSL_OFF_MODE, r);
    `CHK(r, 32'h2)
    `CHK(deep_sleep, 1'b0)
    wr(`SSL_OFF_MODE, 32'h0);
    // every high-side setting against several low-side settings
    foreach (lv[j]) begin
      wr(`SSL_OFF_LCTL, {26'h0, lv[j]});
      for (int h = 0; h < 64; h++) begin
        wr(`SSL_OFF_HCTL, h);
        tick(1);
        rd(`SSL_OFF_STAT, r);
        `CHK(r[3:2], act(h[0], h[2]))
        `CHK(r[5:4], act(h[4], h[5]))
        `CHK(high_sup_state, act(h[0], h[2]))
        `CHK(high_mon_state, act(h[4], h[5]))
        `CHK(r[6], aff(6'(h), lv[j]))
        `CHK(r[7], !lfast(lv[j]))
      end
    end
    // deep entries with only the hazard event unmasked
    wr(`SSL_OFF_IE, 32'h4);
    rd(`SSL_OFF_IE, r);
    `CHK(r, 32'h4)
    foreach (hv[k]) deep_case(hv[k], 6'h00, 1'b1);
    deep_case(6'h07, 6'h11, 1'b1);
    deep_case(6'h07, 6'h00, 1'b0);
    // second reset in mid-run returns HCTL and the status bits to their reset values
    wr(`SSL_OFF_HCTL, 32'h3F);
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    tick(2);
    `CHK(hreadyout, 1'b1)
    `CHK(irq, 1'b0)
    rd(`SSL_OFF_HCTL, r);
    `CHK(r, 32'h0)
    rd(`SSL_OFF_STAT, r);
    `CHK(r[8:0], 9'h0)
    results();
  end
endmodule // ssl_supervisor_bench
